// File: level_trigger_acquisition_timing.v
// Behaviour
// - Exposure length equals trigger pulse width
// - Trigger event registered shortly after rising edge
// - Programmable acquisition delay, microsecond steps
// - Programmable single strobe delay and width
// - Single strobe low when exposure ends
// - Continuous strobe toggles, forced low at end
// - Fixed pre-exposure hold before acquisition delay
// - Short pulse flags error, zeros spectrum
// - Last continuous strobe period may truncate
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`include "level_trig_regs.vh"
`default_nettype none
module level_trigger_acquisition_timing (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire ext_trigger_i,
  output reg single_strobe_o,
  output reg cont_strobe_o,
  output reg exposing_o,
  output reg zero_spectrum_o,
  output reg irq_o
);
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_PRE = 6'h02;
  localparam [5:0] S_DELAY = 6'h04;
  localparam [5:0] S_EXPOSE = 6'h08;
  localparam [5:0] S_POST = 6'h10;
  localparam [5:0] S_WAIT_LOW = 6'h20;

  reg [5:0] state;
  reg [1:0] ctrl;
  reg [18:0] acq_delay;
  reg [23:0] ss_delay;
  reg [23:0] ss_width;
  reg [23:0] cs_period;
  reg [3:0] irq_stat;
  reg [3:0] irq_mask;
  reg [23:0] integ_us;
  reg trig_s1;
  reg trig_s2;
  reg trig_d;
  reg [4:0] tick_cnt;
  reg us_tick;
  reg [23:0] phase_us;
  reg [23:0] exp_us;
  reg [23:0] cs_cnt;
  reg short_err;
  reg [3:0] ev;
  reg [31:0] next_rdata;
  reg [27:0] pulse_cyc;
  reg pulse_done;
  reg [27:0] exp_cyc;

  function [23:0] pre_hold;
    input v;
    begin
      pre_hold = v ? `V1_PRE_US : `V0_PRE_US;
    end
  endfunction

  function [23:0] post_hold;
    input v;
    begin
      post_hold = v ? `V1_POST_US : `V0_POST_US;
    end
  endfunction

  function [23:0] min_pulse;
    input v;
    begin
      min_pulse = v ? `V1_MIN_US : `V0_MIN_US;
    end
  endfunction

  wire trig_rise = trig_s2 & ~trig_d;
  wire bus_req = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  // Trigger low now, or already seen low since the event
  wire pulse_over = pulse_done | ~trig_s2;
  wire exp_end = (state == S_EXPOSE) && pulse_over && (exp_cyc + 28'd1 >= pulse_cyc);

  // Two-stage synchroniser, then edge history
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_d <= 1'b0;
    end else begin
      trig_s1 <= ext_trigger_i;
      trig_s2 <= trig_s1;
      trig_d <= trig_s2;
    end
  end

  // Microsecond timebase, held cleared in S_IDLE, free-running in every other state
  always @(posedge core_clk_i) begin
    if (!resetn_i || state == S_IDLE) begin
      tick_cnt <= 5'h00;
      us_tick <= 1'b0;
    end else if (tick_cnt == `TICKS_PER_US - 5'd1) begin
      tick_cnt <= 5'h00;
      us_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 5'd1;
      us_tick <= 1'b0;
    end
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    case (avs_address_i)
      `REG_CTRL: next_rdata = {30'h0, ctrl};
      `REG_ACQ_DELAY: next_rdata = {13'h0, acq_delay};
      `REG_SS_DELAY: next_rdata = {8'h00, ss_delay};
      `REG_SS_WIDTH: next_rdata = {8'h00, ss_width};
      `REG_CS_PERIOD: next_rdata = {8'h00, cs_period};
      `REG_STATUS: next_rdata = {25'h0, short_err, state};
      `REG_IRQ_STAT: next_rdata = {28'h0, irq_stat};
      `REG_IRQ_MASK: next_rdata = {28'h0, irq_mask};
      `REG_INTEG: next_rdata = {8'h00, integ_us};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus slave: one wait cycle, answer on the second edge
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      ctrl <= 2'h0;
      acq_delay <= 19'h00000;
      ss_delay <= 24'h000000;
      ss_width <= 24'h000000;
      cs_period <= 24'h000000;
      irq_mask <= 4'h0;
    end else begin
      avs_waitrequest_o <= ~bus_req;
      if (bus_req && avs_read_i)
        avs_readdata_o <= next_rdata;
      if (bus_req && avs_write_i) begin
        case (avs_address_i)
          `REG_CTRL: ctrl <= avs_writedata_i[1:0];
          // Delay saturates at its documented ceiling
          `REG_ACQ_DELAY: begin
            if (avs_writedata_i[18:0] > `ACQ_DELAY_MAX_US)
              acq_delay <= `ACQ_DELAY_MAX_US;
            else
              acq_delay <= avs_writedata_i[18:0];
          end
          `REG_SS_DELAY: ss_delay <= avs_writedata_i[23:0];
          `REG_SS_WIDTH: ss_width <= avs_writedata_i[23:0];
          `REG_CS_PERIOD: cs_period <= avs_writedata_i[23:0];
          `REG_IRQ_MASK: irq_mask <= avs_writedata_i[3:0];
          default: ;
        endcase
      end
    end
  end

  // Sticky events; a new event wins over the read clear
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      irq_stat <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      if (bus_req && avs_read_i && avs_address_i == `REG_IRQ_STAT)
        irq_stat <= ev;
      else
        irq_stat <= irq_stat | ev;
      irq_o <= |((irq_stat | ev) & irq_mask);
    end
  end

  always @* begin
    ev = 4'h0;
    ev[`EV_TRIGGER] = (state == S_IDLE) && ctrl[`CTRL_ARM] && trig_rise;
    ev[`EV_DONE] = (state == S_POST) && us_tick && phase_us + 24'd1 >= post_hold(ctrl[1]);
    ev[`EV_SHORT] = exp_end && exp_us < min_pulse(ctrl[1]);
    ev[`EV_WIDTH] = exp_end;
  end

  // pulse width in clock cycles from the event
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pulse_cyc <= 28'h0000000;
      pulse_done <= 1'b0;
    end else if (state == S_IDLE) begin
      pulse_cyc <= ev[`EV_TRIGGER] ? 28'h0000001 : 28'h0000000;
      pulse_done <= 1'b0;
    end else if (!pulse_done) begin
      if (!trig_s2)
        pulse_done <= 1'b1;
      else if (pulse_cyc != 28'hFFFFFFF)
        pulse_cyc <= pulse_cyc + 28'd1;
    end
  end

  // Acquisition sequencer
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state <= S_IDLE;
      phase_us <= 24'h000000;
      exp_us <= 24'h000000;
      integ_us <= 24'h000000;
      short_err <= 1'b0;
      zero_spectrum_o <= 1'b0;
      exposing_o <= 1'b0;
      exp_cyc <= 28'h0000000;
    end else begin
      if (us_tick)
        phase_us <= phase_us + 24'd1;
      case (state)
        S_IDLE: begin
          phase_us <= 24'h000000;
          if (ev[`EV_TRIGGER]) begin
            state <= S_PRE;
            short_err <= 1'b0;
          end
        end
        S_PRE: begin
          if (us_tick && phase_us + 24'd1 >= pre_hold(ctrl[1])) begin
            state <= S_DELAY;
            phase_us <= 24'h000000;
          end
        end
        S_DELAY: begin
          if (phase_us >= {5'h00, acq_delay}) begin
            state <= S_EXPOSE;
            phase_us <= 24'h000000;
            exp_us <= 24'h000000;
            exp_cyc <= 28'h0000000;
            exposing_o <= 1'b1;
          end
        end
        // exposure lasts the measured pulse width
        S_EXPOSE: begin
          exp_cyc <= exp_cyc + 28'd1;
          if (us_tick)
            exp_us <= exp_us + 24'd1;
          if (exp_end) begin
            state <= S_POST;
            phase_us <= 24'h000000;
            exposing_o <= 1'b0;
            integ_us <= exp_us;
            short_err <= ev[`EV_SHORT];
            zero_spectrum_o <= ev[`EV_SHORT];
          end
        end
        S_POST: begin
          if (ev[`EV_DONE])
            state <= trig_s2 ? S_WAIT_LOW : S_IDLE;
        end
        S_WAIT_LOW: begin
          if (!trig_s2)
            state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Strobes run only inside exposure
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      single_strobe_o <= 1'b0;
      cont_strobe_o <= 1'b0;
      cs_cnt <= 24'h000000;
    end else if (state != S_EXPOSE || exp_end) begin
      single_strobe_o <= 1'b0;
      cont_strobe_o <= 1'b0;
      cs_cnt <= 24'h000000;
    end else begin
      single_strobe_o <= (exp_us >= ss_delay) && (exp_us - ss_delay < ss_width);
      // half-period toggle, last period may truncate
      if (cs_period == 24'h000000) begin
        cont_strobe_o <= 1'b0;
      end else if (us_tick) begin
        if (cs_cnt + 24'd1 >= cs_period) begin
          cs_cnt <= 24'h000000;
          cont_strobe_o <= 1'b0;
        end else begin
          cs_cnt <= cs_cnt + 24'd1;
          cont_strobe_o <= (cs_cnt + 24'd1) < {1'b0, cs_period[23:1]};
        end
      end else if (cs_cnt == 24'h000000) begin
        cont_strobe_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: level_trig_regs.vh
`ifndef LEVEL_TRIG_REGS_VH
`define LEVEL_TRIG_REGS_VH
// Register word offsets
`define REG_CTRL 4'h0
`define REG_ACQ_DELAY 4'h1
`define REG_SS_DELAY 4'h2
`define REG_SS_WIDTH 4'h3
`define REG_CS_PERIOD 4'h4
`define REG_STATUS 4'h5
`define REG_IRQ_STAT 4'h6
`define REG_IRQ_MASK 4'h7
`define REG_INTEG 4'h8
// Control fields
`define CTRL_ARM 0
`define CTRL_VARIANT 1
// Event bits
`define EV_TRIGGER 0
`define EV_DONE 1
`define EV_SHORT 2
`define EV_WIDTH 3
// Timing
`define CLK_MHZ 25
`define TICKS_PER_US 5'd25
`define ACQ_DELAY_MAX_US 19'd335500
// Variant 0 holds and minimum pulse, microseconds
`define V0_PRE_US 24'd3706
`define V0_POST_US 24'd3706
`define V0_MIN_US 24'd3800
// Variant 1 holds and minimum pulse, microseconds
`define V1_PRE_US 24'd6
`define V1_POST_US 24'd4977
`define V1_MIN_US 24'd7200
// Trigger delay: 20 ns min, 30 ns max; one cycle of 40 ns after sync
`define TRIG_DELAY_MIN_NS 20
`define TRIG_DELAY_MAX_NS 30
`endif

// File: level_trig_props_properties.sv
`default_nettype none
module level_trig_props (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic ext_trigger_i,
  input wire logic single_strobe_o,
  input wire logic cont_strobe_o,
  input wire logic exposing_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered");
  AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  AST_WAIT_IDLE: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("answer without request");
  AST_RD_HOLD: assert property (avs_waitrequest_o |-> $stable(avs_readdata_o))
    else $error("read data moved");
  AST_EXP_END: assert property ($fell(exposing_o) |-> !ext_trigger_i)
    else $error("exposure ended with trigger high");
  int trig_len = 0;
  int exp_len = 0;
  logic trig_prev = 1'b0;
  always @(posedge core_clk_i) begin
    trig_prev <= ext_trigger_i;
    if (ext_trigger_i && !trig_prev)
      trig_len <= 1;
    else if (ext_trigger_i)
      trig_len <= trig_len + 1;
    exp_len <= exposing_o ? exp_len + 1 : 0;
  end
  AST_EXP_LEN: assert property ($fell(exposing_o) |-> exp_len == trig_len)
    else $error("exposure length differs from pulse width");
  AST_SS_END: assert property (!exposing_o && !$past(exposing_o) |-> !single_strobe_o)
    else $error("single strobe outside exposure");
  AST_CS_END: assert property (!exposing_o && !$past(exposing_o) |-> !cont_strobe_o)
    else $error("continuous strobe outside exposure");
  cover property ($rose(exposing_o));
  cover property ($rose(cont_strobe_o));
  cover property ($rose(irq_o));
endmodule
bind level_trigger_acquisition_timing level_trig_props level_trig_props_i (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .ext_trigger_i(ext_trigger_i),
  .single_strobe_o(single_strobe_o), .cont_strobe_o(cont_strobe_o),
  .exposing_o(exposing_o), .irq_o(irq_o));
`default_nettype wire

// File: level_trig_source.sv
`default_nettype none
module level_trig_source (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [31:0] cycles_i,
  output logic trig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = 0;
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= cycles_i;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  assign trig_o = left > 0;
endmodule
`default_nettype wire

// File: tb_level_trigger_acquisition_timing.sv
`include "level_trig_regs.vh"
`default_nettype none
module tb_level_trigger_acquisition_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0, rd = 1'h0, wr = 1'h0, go = 1'h0, cprev = 1'h0;
  logic trig, wq, ss, cs, ex, zs, irq;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, plen = 32'h0, rdat, q;
  int failures = 0, checked = 0, cyc = 0, ecnt = 0, scnt = 0, crise = 0, lat;
  level_trigger_acquisition_timing level_trigger_acquisition_timing_i (
    .core_clk_i(clk), .resetn_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .ext_trigger_i(trig), .single_strobe_o(ss), .cont_strobe_o(cs), .exposing_o(ex),
    .zero_spectrum_o(zs), .irq_o(irq));
  level_trig_source level_trig_source_i (.clk_i(clk), .go_i(go), .cycles_i(plen),
    .trig_o(trig));
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ex) ecnt++;
    if (ss) scnt++;
    if (cs && !cprev) crise++;
    cprev <= cs;
    if (cyc > 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s, input int t);
    checked++;
    if ($isunknown(s) || (s > e ? s - e : e - s) > t) begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wq !== 1'h0);
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  function int exp_ss(int d, int h, int w);
    return ((d + h < w ? d + h : w) - d) * 25;
  endfunction
  initial begin
    int acq, ssd, ssw, per, w, m;
    void'($urandom(74061));
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    bus(1'h1, `REG_ACQ_DELAY, 32'hFFFFFFFF);
    bus(1'h0, `REG_ACQ_DELAY, 32'h0);
    chk("acq_delay", `ACQ_DELAY_MAX_US, q, 0);
    bus(1'h0, 4'hF, 32'h0);
    chk("unmapped", 0, q, 0);
    for (int i = 0; i < 3; i++) begin
      acq = $urandom % 4;
      ssd = $urandom % 4;
      ssw = i == 0 ? 200 : 1 + $urandom % 4;
      per = i == 2 ? 0 : 2 + $urandom % 4;
      w = 20 + $urandom % 20;
      m = i == 1 ? 0 : 15;
      bus(1'h1, `REG_ACQ_DELAY, acq);
      bus(1'h1, `REG_SS_DELAY, ssd);
      bus(1'h1, `REG_SS_WIDTH, ssw);
      bus(1'h1, `REG_CS_PERIOD, per);
      bus(1'h1, `REG_IRQ_MASK, m);
      bus(1'h1, `REG_CTRL, 32'h3);
      ecnt = 0;
      scnt = 0;
      crise = 0;
      lat = 0;
      plen <= w * 25;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      while (!ex && lat < 400) begin
        @(posedge clk);
        lat++;
      end
      chk("start", `V1_PRE_US * `TICKS_PER_US + acq * 25 + 3, lat, 3);
      for (int k = 0; ex && k < 2000; k++) @(posedge clk);
      repeat (8) @(posedge clk);
      chk("exposure", w * 25, ecnt, 3);
      chk("single", exp_ss(ssd, ssw, w), scnt, 3);
      chk("cont", per == 0 ? 0 : (w + per - 1) / per, crise, 0);
      chk("zero", 1, zs, 0);
      chk("irq", m != 0, irq, 0);
      bus(1'h0, `REG_INTEG, 32'h0);
      chk("integ", w, q, 1);
      bus(1'h0, `REG_IRQ_STAT, 32'h0);
      chk("short_ev", 1, q[`EV_SHORT], 0);
      chk("ev_bits", (1 << `EV_TRIGGER) | (1 << `EV_SHORT) | (1 << `EV_WIDTH), q[3:0], 0);
      bus(1'h0, `REG_IRQ_STAT, 32'h0);
      chk("cleared", 0, q[`EV_SHORT], 0);
      chk("irq_clr", 0, irq, 0);
      rst_n <= 1'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
